//--- bench/cpu_port_model.sv
// microprocessor on the multiplexed register port
// drives at the falling edge; released bus shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module cpu_port_model
(
    // clock
    input  wire logic       clk_i,
    // device read side
    input  wire logic [7:0] rdata_i,
    input  wire logic       rdata_oe_i,
    // port strobes
    output var  logic       ale_o = 1'b0,
    output var  logic       cs_n_o = 1'b1,
    output var  logic       rd_n_o = 1'b1,
    output var  logic       wr_n_o = 1'b1,
    output var  logic [7:0] ad_o = 8'h00
);
    task automatic put_addr(input logic [7:0] a);
        @(negedge clk_i);
        ale_o = 1'b1;
        ad_o = a;
        @(negedge clk_i);
        ale_o = 1'b0;
        cs_n_o = 1'b0;
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        put_addr(a);
        ad_o = d;
        wr_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        wr_n_o = 1'b1;
        cs_n_o = 1'b1;
        ad_o = ~d;
        @(negedge clk_i);
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
        put_addr(a);
        ad_o = ~a;
        rd_n_o = 1'b0;
        d = 8'h00;
        ok = 1'b0;
        for (int i = 0; i < 6 && !ok; i++)
        begin
            @(negedge clk_i);
            if (rdata_oe_i === 1'b1)
            begin
                d = rdata_i;
                ok = 1'b1;
            end
        end
        rd_n_o = 1'b1;
        cs_n_o = 1'b1;
        @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

//--- bench/seq_store_access_checker.sv
// concurrent checks on the top ports
// bound to the top module; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none

module seq_store_access_checker
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // port strobes
    input  wire logic        cs_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        ad_oe_o,
    // scsi data
    input  wire logic [15:0] scsi_data_line_bits_o,
    input  wire logic [15:0] scsi_data_line_bits_oe_o,
    input  wire logic        low_level_drive_enable_i,
    input  wire logic        initiator_group_i,
    input  wire logic        target_group_i,
    input  wire logic        io_line_i,
    // responses
    input  wire logic        being_selected_i,
    input  wire logic        selection_hold_bit_i,
    input  wire logic        reselected_i,
    input  wire logic        reselection_hold_bit_i,
    input  wire logic        external_dma_request_i,
    input  wire logic        automatic_response_bit_i,
    input  wire logic        seq_start_o,
    input  wire logic [6:0]  seq_start_addr_o,
    input  wire logic        seq_start_initiator_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    wire logic sel_c = being_selected_i & selection_hold_bit_i;
    wire logic rsl_c = reselected_i & reselection_hold_bit_i;
    wire logic dma_c = external_dma_request_i & automatic_response_bit_i;
    wire logic drv_c = low_level_drive_enable_i
                       & ((initiator_group_i & ~io_line_i) | (target_group_i & io_line_i));

    // read strobe taken from idle, then held
    sequence rd_start;
        !cs_n_i && $fell(rd_n_i) && wr_n_i;
    endsequence
    sequence rd_held;
        rd_start ##1 (!rd_n_i && !cs_n_i);
    endsequence

    chk_drive_role: assert property (1'b1 |=> scsi_data_line_bits_oe_o == {16{$past(drv_c)}})
        else $error("data drive enable wrong");
    chk_data_write: assert property ($changed(scsi_data_line_bits_o) |-> $past(wr_n_i) && !$past(wr_n_i, 2))
        else $error("data value changed without write");
    chk_read_answer: assert property (rd_held |=> ad_oe_o)
        else $error("read data late");
    chk_read_release: assert property (ad_oe_o && rd_n_i |=> !ad_oe_o)
        else $error("read drive not released");
    chk_read_cause: assert property (ad_oe_o |-> !$past(rd_n_i) && !$past(cs_n_i))
        else $error("bus driven without read");
    chk_sel_start: assert property ($rose(sel_c) |=> seq_start_o && !seq_start_initiator_o)
        else $error("selection start missing");
    chk_resel_start: assert property ($rose(rsl_c) && !$rose(sel_c) |=> seq_start_o && seq_start_initiator_o)
        else $error("reselection start missing");
    chk_dma_start: assert property ($rose(dma_c) && !$rose(sel_c) && !$rose(rsl_c)
        |=> seq_start_o && $stable(seq_start_initiator_o))
        else $error("dma start missing");
    chk_start_cause: assert property (seq_start_o |-> $past(sel_c) || $past(rsl_c) || $past(dma_c))
        else $error("start without cause");
    chk_start_addr: assert property (!seq_start_o |-> $stable(seq_start_addr_o))
        else $error("start address moved");
endmodule

bind scsi_sequencer_store_access seq_store_access_checker seq_store_access_checker_inst (.*);
`default_nettype wire

//--- bench/tb_scsi_sequencer_store_access.sv
// self-checking bench for the store access block
// inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "seq_store_regs.svh"

module tb_scsi_sequencer_store_access;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    wire logic   ale, cs_n, rd_n, wr_n;
    wire logic [7:0] ad_m;
    wire logic [7:0] ad_o;
    wire logic   ad_oe;
    wire logic [7:0] ad_bus = (ad_oe === 1'b1) ? ad_o : ad_m;
    logic [15:0] scsi_in = 16'hA55A;
    logic [3:0]  role = 4'h0;
    logic [5:0]  ev = 6'h00;
    logic [6:0]  fetch_a = 7'h00;
    wire logic [29:0] fetch_w;
    wire logic [15:0] sd_o;
    wire logic [15:0] sd_oe;
    wire logic   st;
    wire logic [6:0] st_a;
    wire logic   st_ini;
    int          error_cnt = 0;
    int          checks_done = 0;
    logic [7:0]  regs [4] = '{`OFS_STORE_ADDR, `OFS_SEL_START, `OFS_RESEL_START, `OFS_DMA_START};

    cpu_port_model cpu_port_model_inst (.clk_i(clk_i), .rdata_i(ad_o), .rdata_oe_i(ad_oe),
        .ale_o(ale), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .ad_o(ad_m));

    scsi_sequencer_store_access scsi_sequencer_store_access_inst (.clk_i(clk_i), .rst_i(rst_i),
        .ale_i(ale), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .ad_i(ad_bus), .ad_o(ad_o),
        .ad_oe_o(ad_oe), .scsi_data_line_bits_i(scsi_in), .scsi_data_line_bits_o(sd_o),
        .scsi_data_line_bits_oe_o(sd_oe), .low_level_drive_enable_i(role[3]),
        .initiator_group_i(role[2]), .target_group_i(role[1]), .io_line_i(role[0]),
        .being_selected_i(ev[0]), .selection_hold_bit_i(ev[1]), .reselected_i(ev[2]),
        .reselection_hold_bit_i(ev[3]), .external_dma_request_i(ev[4]),
        .automatic_response_bit_i(ev[5]), .fetch_addr_i(fetch_a), .fetch_word_o(fetch_w),
        .seq_start_o(st), .seq_start_addr_o(st_a), .seq_start_initiator_o(st_ini));

    initial
    begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu_port_model_inst.write_reg(a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        bit         ok;
        cpu_port_model_inst.read_reg(a, d, ok);
        if (!ok)
            d = 'x;
        chk(32'(d), 32'(e));
    endtask

    task automatic see(input int n, output logic s);
        s = 1'b0;
        repeat (n)
        begin
            @(negedge clk_i);
            if (st === 1'b1)
                s = 1'b1;
        end
    endtask

    function automatic logic [31:0] wd(input logic [7:0] k);
        return 32'h9A3C_E65F ^ {4{k}};
    endfunction

    task automatic results;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        #(5000 * 50);
        error_cnt++;
        results;
    end

    initial
    begin
        logic [31:0] t;
        logic        s;
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        for (int i = 0; i < 4; i++)
            rd(regs[i], 8'h00);
        for (int i = 1; i < 4; i++)
        begin
            wr(regs[i], 8'h80 | 8'(8'h11 * i));
            rd(regs[i], 8'(8'h11 * i));
        end
        wr(`OFS_STORE_ADDR, 8'hFF);
        rd(`OFS_STORE_ADDR, 8'h7F);
        wr(8'h50, 8'hFF);
        rd(8'h50, 8'h00);
        wr(`OFS_STORE_ADDR, 8'h7D);
        for (int k = 0; k < 4; k++)
        begin
            t = wd(8'(k));
            for (int b = 0; b < 4; b++)
                wr(8'(8'h24 + 2 * b), t[8 * b +: 8]);
        end
        rd(`OFS_STORE_ADDR, 8'h02);
        fetch_a = 7'h7E;
        repeat (2) @(negedge clk_i);
        t = wd(8'h01);
        chk(32'(fetch_w), {2'b00, t[29:0]});
        rst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        rd(`OFS_STORE_ADDR, 8'h00);
        wr(`OFS_STORE_ADDR, 8'h7D);
        for (int k = 0; k < 4; k++)
        begin
            t = wd(8'(k));
            for (int b = 0; b < 4; b++)
                rd(8'(8'h24 + 2 * b), (b == 3) ? {2'b00, t[29:24]} : t[8 * b +: 8]);
        end
        rd(`OFS_STORE_ADDR, 8'h02);
        rd(`OFS_DATA_LOW, 8'h5A);
        rd(`OFS_DATA_HIGH, 8'hA5);
        wr(`OFS_DATA_LOW, 8'h3C);
        wr(`OFS_DATA_HIGH, 8'hC3);
        chk(32'(sd_oe), 32'h0);
        chk(32'(sd_o), 32'h0000_C33C);
        for (int m = 0; m < 16; m++)
        begin
            role = 4'(m);
            repeat (2) @(negedge clk_i);
            s = role[3] & ((role[2] & ~role[0]) | (role[1] & role[0]));
            chk(32'(sd_oe), 32'({16{s}}));
        end
        for (int i = 1; i < 4; i++)
            wr(regs[i], 8'(8'h11 * i));
        for (int e = 0; e < 3; e++)
        begin
            ev = 6'(1 << (2 * e));
            see(3, s);
            chk(32'(s), 32'h0);
            ev[2 * e + 1] = 1'b1;
            see(4, s);
            chk(32'(s), 32'h1);
            chk(32'(st_a), 32'(8'h11 * (e + 1)));
            chk(32'(st_ini), 32'(e != 0));
        end
        results;
    end
endmodule
`default_nettype wire

//--- rtl/control_store.sv
// control store: 127 words of 30 bits in flip-flops, byte-lane writes
// assumes one clock; contents are never reset
`timescale 1ns/1ps
`default_nettype none
`include "seq_store_regs.svh"

module control_store
(
    // clock
    input  wire logic                       clk_i,
    // microprocessor side
    input  wire seq_store_pkg::store_addr_t cpu_addr_i,
    input  wire logic [3:0]                 cpu_lane_we_i,
    input  wire seq_store_pkg::byte_t       cpu_wdata_i,
    output logic [29:0]                     cpu_rdata_o,
    // sequencer fetch side
    input  wire seq_store_pkg::store_addr_t fetch_addr_i,
    output logic [29:0]                     fetch_word_o
);

    seq_store_pkg::store_word_t mem_reg [0:`STORE_DEPTH-1];
    seq_store_pkg::store_word_t fetch_reg;

    // contents survive reset
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1)
        begin : g_lane
            localparam int LO = lane * 8;
            localparam int W  = (lane == 3) ? `PORT3_FIELD_W : 8;
            always_ff @(posedge clk_i)
            begin
                if (cpu_lane_we_i[lane] && (cpu_addr_i < 7'(`STORE_DEPTH)))
                begin
                    mem_reg[cpu_addr_i][LO +: W] <= cpu_wdata_i[W-1:0]; // R6 R7 R9
                end
            end
        end
    endgenerate

    always_comb
    begin
        cpu_rdata_o = (cpu_addr_i < 7'(`STORE_DEPTH)) ? mem_reg[cpu_addr_i] : '0; // R7
    end

    always_ff @(posedge clk_i)
    begin
        fetch_reg <= (fetch_addr_i < 7'(`STORE_DEPTH)) ? mem_reg[fetch_addr_i] : '0;
    end

    assign fetch_word_o = fetch_reg;

endmodule
`default_nettype wire

//--- rtl/scsi_sequencer_store_access.sv
// register logic of the SCSI section: data lines, control store port, start addresses
// assumes an 8-bit multiplexed port with ALE, chip select and active-low strobes,
// all synchronous to clk_i
//
// Notes on behaviour
// R1 - low data byte reads bus lines 7..0; writes drive them when direction suits role
// R2 - high data byte reads bus lines 15..8; writes drive them likewise
// R3 - data writes always accepted, driven only while low-level drive enable is 1
// R4 - address register holds 7-bit control store word address
// R5 - each access to byte port 3 increments the address, wrapping modulo 127
// R6 - 30-bit word across four byte ports; port 3 holds bits 29..24
// R7 - byte ports reach the word at the current address, read and write
// R8 - software writes start address, then four ports per word in order
// R9 - reset leaves control store contents untouched
// R10 - selection with hold bit starts sequencer at selection start address
// R11 - reselection with hold bit starts sequencer as initiator at its address
// R12 - dma request with response bit starts sequencer at dma start address
// R13 - unused upper bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "seq_store_regs.svh"

module scsi_sequencer_store_access
(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // microprocessor port
    input  wire logic                  ale_i,
    input  wire logic                  cs_n_i,
    input  wire logic                  rd_n_i,
    input  wire logic                  wr_n_i,
    input  wire logic [7:0]            ad_i,
    output logic [7:0]                 ad_o,
    output logic                       ad_oe_o,
    // scsi data lines
    input  wire logic [15:0]           scsi_data_line_bits_i,
    output logic [15:0]                scsi_data_line_bits_o,
    output logic [15:0]                scsi_data_line_bits_oe_o,
    // bus role and direction
    input  wire logic                  low_level_drive_enable_i,
    input  wire logic                  initiator_group_i,
    input  wire logic                  target_group_i,
    input  wire logic                  io_line_i,
    // response conditions
    input  wire logic                  being_selected_i,
    input  wire logic                  selection_hold_bit_i,
    input  wire logic                  reselected_i,
    input  wire logic                  reselection_hold_bit_i,
    input  wire logic                  external_dma_request_i,
    input  wire logic                  automatic_response_bit_i,
    // sequencer
    input  wire logic [6:0]            fetch_addr_i,
    output logic [29:0]                fetch_word_o,
    output logic                       seq_start_o,
    output logic [6:0]                 seq_start_addr_o,
    output logic                       seq_start_initiator_o
);

    // register select decode, used by read and write paths
    function automatic seq_store_pkg::reg_sel_e decode(input logic [7:0] ofs);
        case (ofs)
            `OFS_DATA_LOW:    decode = seq_store_pkg::SEL_DLOW;
            `OFS_DATA_HIGH:   decode = seq_store_pkg::SEL_DHIGH;
            `OFS_STORE_ADDR:  decode = seq_store_pkg::SEL_ADDR;
            `OFS_STORE_PORT0: decode = seq_store_pkg::SEL_PORT0;
            `OFS_STORE_PORT1: decode = seq_store_pkg::SEL_PORT1;
            `OFS_STORE_PORT2: decode = seq_store_pkg::SEL_PORT2;
            `OFS_STORE_PORT3: decode = seq_store_pkg::SEL_PORT3;
            `OFS_SEL_START:   decode = seq_store_pkg::SEL_SSEL;
            `OFS_RESEL_START: decode = seq_store_pkg::SEL_SRESEL;
            `OFS_DMA_START:   decode = seq_store_pkg::SEL_SDMA;
            default:          decode = seq_store_pkg::SEL_NONE;
        endcase
    endfunction

    // port state
    logic [7:0]                  addr_lat_reg, addr_lat_next;
    seq_store_pkg::port_phase_e  phase_reg, phase_next;
    logic [7:0]                  wdata_reg, wdata_next;
    logic [7:0]                  rdata_reg, rdata_next;
    logic                        rd_oe_reg, rd_oe_next;

    // register state
    seq_store_pkg::store_addr_t  store_addr_reg, store_addr_next;
    seq_store_pkg::store_addr_t  sel_start_reg, sel_start_next;
    seq_store_pkg::store_addr_t  resel_start_reg, resel_start_next;
    seq_store_pkg::store_addr_t  dma_start_reg, dma_start_next;
    logic [15:0]                 data_out_reg, data_out_next;
    logic [15:0]                 data_oe_reg, data_oe_next;

    // store and start select wiring
    logic [3:0]                  lane_we;
    logic [29:0]                 store_rdata;
    seq_store_pkg::reg_sel_e     sel;
    logic                        access_end;
    logic                        dir_ok;

    always_comb
    begin
        sel        = decode(addr_lat_reg);
        access_end = 1'b0;
        addr_lat_next = addr_lat_reg;
        phase_next = phase_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        rd_oe_next = 1'b0;
        if (ale_i)
        begin
            addr_lat_next = ad_i;
        end
        case (phase_reg)
            seq_store_pkg::PH_IDLE:
            begin
                if (!cs_n_i && !rd_n_i)
                begin
                    phase_next = seq_store_pkg::PH_READ;
                end
                else if (!cs_n_i && !wr_n_i)
                begin
                    phase_next = seq_store_pkg::PH_WRITE;
                    wdata_next = ad_i;
                end
            end
            seq_store_pkg::PH_READ:
            begin
                rd_oe_next = 1'b1;
                case (sel)
                    seq_store_pkg::SEL_DLOW:   rdata_next = scsi_data_line_bits_i[7:0]; // R1
                    seq_store_pkg::SEL_DHIGH:  rdata_next = scsi_data_line_bits_i[15:8]; // R2
                    seq_store_pkg::SEL_ADDR:   rdata_next = {1'b0, store_addr_reg}; // R4 R13
                    seq_store_pkg::SEL_PORT0:  rdata_next = store_rdata[7:0]; // R7
                    seq_store_pkg::SEL_PORT1:  rdata_next = store_rdata[15:8];
                    seq_store_pkg::SEL_PORT2:  rdata_next = store_rdata[23:16];
                    seq_store_pkg::SEL_PORT3:  rdata_next = {2'b00, store_rdata[29:24]}; // R6 R13
                    seq_store_pkg::SEL_SSEL:   rdata_next = {1'b0, sel_start_reg};
                    seq_store_pkg::SEL_SRESEL: rdata_next = {1'b0, resel_start_reg};
                    seq_store_pkg::SEL_SDMA:   rdata_next = {1'b0, dma_start_reg};
                    default:                   rdata_next = 8'h00;
                endcase
                if (rd_n_i || cs_n_i)
                begin
                    phase_next = seq_store_pkg::PH_IDLE;
                    access_end = 1'b1;
                    rd_oe_next = 1'b0;
                end
            end
            seq_store_pkg::PH_WRITE:
            begin
                wdata_next = ad_i;
                if (wr_n_i || cs_n_i)
                begin
                    phase_next = seq_store_pkg::PH_IDLE;
                    wdata_next = wdata_reg;
                    access_end = 1'b1;
                end
            end
            default:
            begin
                phase_next = seq_store_pkg::PH_IDLE;
            end
        endcase
    end

    // register writes commit when the write strobe is released
    always_comb
    begin
        store_addr_next  = store_addr_reg;
        sel_start_next   = sel_start_reg;
        resel_start_next = resel_start_reg;
        dma_start_next   = dma_start_reg;
        data_out_next    = data_out_reg;
        lane_we          = 4'h0;
        if (access_end && (phase_reg == seq_store_pkg::PH_WRITE))
        begin
            case (sel)
                seq_store_pkg::SEL_DLOW:   data_out_next[7:0]  = wdata_reg; // R1 R3
                seq_store_pkg::SEL_DHIGH:  data_out_next[15:8] = wdata_reg; // R2 R3
                seq_store_pkg::SEL_ADDR:   store_addr_next = wdata_reg[6:0]; // R4 R13
                seq_store_pkg::SEL_PORT0:  lane_we = 4'h1; // R7
                seq_store_pkg::SEL_PORT1:  lane_we = 4'h2;
                seq_store_pkg::SEL_PORT2:  lane_we = 4'h4;
                seq_store_pkg::SEL_PORT3:  lane_we = 4'h8; // R6
                seq_store_pkg::SEL_SSEL:   sel_start_next = wdata_reg[6:0]; // R13
                seq_store_pkg::SEL_SRESEL: resel_start_next = wdata_reg[6:0];
                seq_store_pkg::SEL_SDMA:   dma_start_next = wdata_reg[6:0];
                default:                   lane_we = 4'h0;
            endcase
        end
        if (access_end && (sel == seq_store_pkg::SEL_PORT3))
        begin
            if (store_addr_reg >= `STORE_ADDR_LAST)
            begin
                store_addr_next = 7'h00; // R5
            end
            else
            begin
                store_addr_next = store_addr_reg + 7'h01; // R5
            end
        end
    end

    // initiator drives data with I/O negated, target with I/O asserted
    always_comb
    begin
        dir_ok = (initiator_group_i && !io_line_i) || (target_group_i && io_line_i); // R1 R2
        data_oe_next = (low_level_drive_enable_i && dir_ok) ? 16'hFFFF : 16'h0000; // R3
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            addr_lat_reg    <= 8'h00;
            phase_reg       <= seq_store_pkg::PH_IDLE;
            wdata_reg       <= 8'h00;
            rdata_reg       <= 8'h00;
            rd_oe_reg       <= 1'b0;
            store_addr_reg  <= `RST_STORE_ADDR;
            sel_start_reg   <= `RST_START_ADDR;
            resel_start_reg <= `RST_START_ADDR;
            dma_start_reg   <= `RST_START_ADDR;
            data_out_reg    <= {`RST_DATA_OUT, `RST_DATA_OUT};
            data_oe_reg     <= 16'h0000;
        end
        else
        begin
            addr_lat_reg    <= addr_lat_next;
            phase_reg       <= phase_next;
            wdata_reg       <= wdata_next;
            rdata_reg       <= rdata_next;
            rd_oe_reg       <= rd_oe_next;
            store_addr_reg  <= store_addr_next;
            sel_start_reg   <= sel_start_next;
            resel_start_reg <= resel_start_next;
            dma_start_reg   <= dma_start_next;
            data_out_reg    <= data_out_next;
            data_oe_reg     <= data_oe_next;
        end
    end

    // storage is not reset
    control_store u_store
    (
        .clk_i        (clk_i),
        .cpu_addr_i   (store_addr_reg),
        .cpu_lane_we_i(lane_we),
        .cpu_wdata_i  (wdata_reg),
        .cpu_rdata_o  (store_rdata),
        .fetch_addr_i (fetch_addr_i),
        .fetch_word_o (fetch_word_o)
    );

    seq_start_select u_start
    (
        .clk_i                   (clk_i),
        .rst_i                   (rst_i),
        .sel_start_i             (sel_start_reg),
        .resel_start_i           (resel_start_reg),
        .dma_start_i             (dma_start_reg),
        .being_selected_i        (being_selected_i),
        .selection_hold_bit_i    (selection_hold_bit_i),
        .reselected_i            (reselected_i),
        .reselection_hold_bit_i  (reselection_hold_bit_i),
        .external_dma_request_i  (external_dma_request_i),
        .automatic_response_bit_i(automatic_response_bit_i),
        .start_o                 (seq_start_o),
        .start_addr_o            (seq_start_addr_o),
        .start_initiator_o       (seq_start_initiator_o)
    );

    assign ad_o                     = rdata_reg;
    assign ad_oe_o                  = rd_oe_reg;
    assign scsi_data_line_bits_o    = data_out_reg;
    assign scsi_data_line_bits_oe_o = data_oe_reg;

endmodule
`default_nettype wire

//--- rtl/seq_start_select.sv
// picks the sequencer start address from the three response events
// assumes event inputs are synchronous levels; output is a registered pulse
`timescale 1ns/1ps
`default_nettype none
`include "seq_store_regs.svh"

module seq_start_select
(
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // start addresses
    input  wire seq_store_pkg::store_addr_t sel_start_i,
    input  wire seq_store_pkg::store_addr_t resel_start_i,
    input  wire seq_store_pkg::store_addr_t dma_start_i,
    // events and enables
    input  wire logic                       being_selected_i,
    input  wire logic                       selection_hold_bit_i,
    input  wire logic                       reselected_i,
    input  wire logic                       reselection_hold_bit_i,
    input  wire logic                       external_dma_request_i,
    input  wire logic                       automatic_response_bit_i,
    // start request to the sequencer
    output logic                            start_o,
    output seq_store_pkg::store_addr_t      start_addr_o,
    output logic                            start_initiator_o
);

    logic                       start_reg, start_next;
    seq_store_pkg::store_addr_t addr_reg, addr_next;
    logic                       init_reg, init_next;
    logic [2:0]                 cause_reg, cause_next;

    // rising edges so a held request starts the sequence once
    always_comb
    begin
        cause_next = {being_selected_i & selection_hold_bit_i,
                      reselected_i & reselection_hold_bit_i,
                      external_dma_request_i & automatic_response_bit_i};
        start_next = 1'b0;
        addr_next  = addr_reg;
        init_next  = init_reg;
        if (cause_next[2] && !cause_reg[2])
        begin
            start_next = 1'b1;
            addr_next  = sel_start_i; // R10
            init_next  = 1'b0;
        end
        else if (cause_next[1] && !cause_reg[1])
        begin
            start_next = 1'b1;
            addr_next  = resel_start_i; // R11
            init_next  = 1'b1;
        end
        else if (cause_next[0] && !cause_reg[0])
        begin
            start_next = 1'b1;
            addr_next  = dma_start_i; // R12
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            start_reg <= 1'b0;
            addr_reg  <= `RST_START_ADDR;
            init_reg  <= 1'b0;
            cause_reg <= 3'h0;
        end
        else
        begin
            start_reg <= start_next;
            addr_reg  <= addr_next;
            init_reg  <= init_next;
            cause_reg <= cause_next;
        end
    end

    assign start_o           = start_reg;
    assign start_addr_o      = addr_reg;
    assign start_initiator_o = init_reg;

endmodule
`default_nettype wire

//--- rtl/seq_store_pkg.sv
// types shared by the sequencer store access block
// no surroundings assumed
package seq_store_pkg;

    typedef logic [6:0]  store_addr_t;
    typedef logic [29:0] store_word_t;
    typedef logic [7:0]  byte_t;

    // register select decoded from the latched port address
    typedef enum logic [9:0] {
        SEL_NONE   = 10'h000,
        SEL_DLOW   = 10'h001,
        SEL_DHIGH  = 10'h002,
        SEL_ADDR   = 10'h004,
        SEL_PORT0  = 10'h008,
        SEL_PORT1  = 10'h010,
        SEL_PORT2  = 10'h020,
        SEL_PORT3  = 10'h040,
        SEL_SSEL   = 10'h080,
        SEL_SRESEL = 10'h100,
        SEL_SDMA   = 10'h200
    } reg_sel_e;

    // access phase of the port
    typedef enum logic [2:0] {
        PH_IDLE  = 3'b001,
        PH_READ  = 3'b010,
        PH_WRITE = 3'b100
    } port_phase_e;

endpackage

//--- rtl/seq_store_regs.svh
// register offsets, field positions and counts for the sequencer store access block
// included by the design files; definitions only
`ifndef SEQ_STORE_REGS_SVH
`define SEQ_STORE_REGS_SVH

// register offsets on the 8-bit multiplexed port
`define OFS_DATA_LOW        8'h1E
`define OFS_DATA_HIGH       8'h20
`define OFS_STORE_ADDR      8'h22
`define OFS_STORE_PORT0     8'h24
`define OFS_STORE_PORT1     8'h26
`define OFS_STORE_PORT2     8'h28
`define OFS_STORE_PORT3     8'h2A
`define OFS_SEL_START       8'h2C
`define OFS_RESEL_START     8'h2E
`define OFS_DMA_START       8'h30

// field layout
`define STORE_ADDR_W        7
`define STORE_WORD_W        30
`define STORE_DEPTH         127
`define STORE_ADDR_LAST     7'h7E
`define PORT3_FIELD_W       6

// reset values
`define RST_STORE_ADDR      7'h00
`define RST_START_ADDR      7'h00
`define RST_DATA_OUT        8'h00

`endif
